// ### gfx_datapath.sv
/*
  Graphics controller datapath: index/data registers, host window decode,
  read map select and colour compare, four write modes, video shift load.
  Assumes single-cycle host I/O strobes, map data returned by map_rvalid,
  and dot/load enables from the video timing logic on the same clock.
*/
// How it works
// - Read-plane field picks the returned map unless compare read or chain-4 is on; odd/even uses only its high bit.
// - Odd/even reads: plane field 0x picks maps 0/1, 1x maps 2/3.
// - 16-colour mode: shift format bit rules, top bits from colour select.
// - 256-colour mode loads shift registers as nibble pairs per byte.
// - Shift MSB first; format bit picks per-map or even/odd bit loading.
// - Mode odd/even bit: even addresses hit maps 0/2, odd maps 1/3.
// - Normal read returns selected map; chain-4 overrides the selection.
// - Read-type bit set returns per-bit colour compare result.
// - Two-bit write-mode field selects write modes 0 to 3.
// - Mode 0: enabled set/reset bytes, else host data rotated right.
// - Mode 2 fills map n with host bit n, then masks.
// - Mode 3: set/reset data, mask is rotated data AND bit mask.
// - Window field decodes 128K A000, 64K A000, 32K B000, 32K B800.
// - Window odd/even bit replaces A0 by a high bit, A0 steers maps.
// - Graphics bit: 0 alphanumeric, 1 graphics; software matches attribute.
// - Compare-enable bits include or exclude each map from comparison.
// - Bit mask on all maps: 0 keeps latch bit, 1 takes new data.
// - Registers 00h to 08h read/write via data port 3CFh.
// - Index register at 3CEh selects register behind the data port.
// - Function field: pass, AND, OR, XOR with latches.
// - Compare bit is 1 where enabled maps equal the compare colour.
// - Enable set/reset bit chooses set/reset or rotated data in mode 0.
`timescale 1ns/1ps
`default_nettype none
`include "gfx_defines.svh"

module gfx_datapath
  import gfx_pkg::*;
(
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        reset,
  // Host I/O port cycles
  input  wire logic [15:0] io_addr,
  input  wire logic        io_wr,
  input  wire logic        io_rd,
  input  wire logic [7:0]  io_wdata,
  output var  logic [7:0]  io_rdata_q,
  // Host memory cycles
  input  wire logic        mem_rd,
  input  wire logic        mem_wr,
  input  wire logic [19:0] host_addr,
  input  wire logic [7:0]  host_wdata,
  output var  logic        host_ready_q,
  output var  logic        host_ack_q,
  output var  logic [7:0]  host_rdata_q,
  // Sequencer and attribute settings
  input  wire logic [3:0]  seq_map_mask,
  input  wire logic        seq_chain4,
  input  wire logic [3:0]  color_select,
  // Display map port
  output var  logic        map_valid_q,
  input  wire logic        map_ready,
  output var  map_req_t    map_req_q,
  input  wire logic        map_rvalid,
  input  wire logic [31:0] map_rdata,
  // Video shift path
  input  wire logic        shift_load,
  input  wire logic        dot_en,
  input  wire logic [31:0] shift_data,
  output var  logic [5:0]  pixel_out_low_q,
  output var  logic        pixel_out_bit6_q,
  output var  logic        pixel_out_bit7_q,
  output var  logic        graphics_mode_q
);

  logic [3:0]  index_q;
  logic [3:0]  setreset_q;
  logic [3:0]  sr_enable_q;
  logic [3:0]  cmp_color_q;
  logic [4:0]  rotate_q;
  logic [1:0]  read_plane_q;
  logic [7:0]  acc_mode_q;
  logic [3:0]  win_ctrl_q;
  logic [3:0]  cmp_en_q;
  logic [7:0]  wr_mask_q;
  logic [31:0] latch_q;
  logic [1:0]  rd_plane_q;
  logic        rd_cmp_q;
  logic [3:0]  prev_nib_q;
  host_state_t state_q;

  wmode_t      wmode;
  alu_fn_t     alu_fn;
  logic        data_wr;
  logic        data_rd;
  logic        win_hit;
  logic [16:0] win_off;
  logic        odd_even;
  logic [15:0] map_addr;
  logic [3:0]  wr_planes;
  logic [1:0]  rd_plane;
  logic [7:0]  rot;
  logic [31:0] wr_src;
  logic [31:0] wr_alu;
  logic [7:0]  wr_bits;
  logic [31:0] wr_word;
  logic [7:0]  cmp_byte;
  logic [7:0]  reg_rd;
  logic        take_rd;
  logic        take_wr;
  map_req_t    fifo_in;
  logic        fifo_in_ready;
  logic        fifo_out_valid;
  map_req_t    fifo_out;
  logic [7:0]  load_val [4];
  logic [3:0]  sr_msb;

  assign wmode    = wmode_t'(acc_mode_q[1:0]);
  assign alu_fn   = alu_fn_t'(rotate_q[4:3]);
  assign data_wr  = io_wr && (io_addr == `GFX_PORT_DATA);
  assign data_rd  = io_rd && (io_addr == `GFX_PORT_DATA);
  assign odd_even = acc_mode_q[`GFX_AM_ODDEVEN] ||
                    win_ctrl_q[`GFX_WC_ODDEVEN];

  // Index register; reserved high bits dropped
  always_ff @(posedge mclk) begin
    if (reset) begin
      index_q <= 4'h0;
    end else if (io_wr && io_addr == `GFX_PORT_INDEX) begin
      index_q <= io_wdata[3:0];
    end
  end

  // Data port writes; reserved bits are never stored
  always_ff @(posedge mclk) begin
    if (reset) begin
      setreset_q   <= 4'h0;
      sr_enable_q  <= 4'h0;
      cmp_color_q  <= 4'h0;
      rotate_q     <= 5'h00;
      read_plane_q <= 2'h0;
      acc_mode_q   <= `GFX_RST_BYTE;
      win_ctrl_q   <= 4'h0;
      cmp_en_q     <= 4'h0;
      wr_mask_q    <= `GFX_RST_MASK;
    end else if (data_wr) begin
      case (index_q)
        `GFX_IDX_SETRESET:  setreset_q   <= io_wdata[3:0];
        `GFX_IDX_SR_ENABLE: sr_enable_q  <= io_wdata[3:0];
        `GFX_IDX_CMP_COLOR: cmp_color_q  <= io_wdata[3:0];
        `GFX_IDX_ROTATE:    rotate_q     <= io_wdata[4:0];
        `GFX_IDX_READ_PLN:  read_plane_q <= io_wdata[1:0];
        `GFX_IDX_ACC_MODE:  acc_mode_q   <= io_wdata & 8'h7B;
        `GFX_IDX_WIN_CTRL:  win_ctrl_q   <= io_wdata[3:0];
        `GFX_IDX_CMP_EN:    cmp_en_q     <= io_wdata[3:0];
        `GFX_IDX_WR_MASK:   wr_mask_q    <= io_wdata;
        default: ;
      endcase
    end
  end

  always_comb begin
    case (index_q)
      `GFX_IDX_SETRESET:  reg_rd = {4'h0, setreset_q};
      `GFX_IDX_SR_ENABLE: reg_rd = {4'h0, sr_enable_q};
      `GFX_IDX_CMP_COLOR: reg_rd = {4'h0, cmp_color_q};
      `GFX_IDX_ROTATE:    reg_rd = {3'h0, rotate_q};
      `GFX_IDX_READ_PLN:  reg_rd = {6'h00, read_plane_q};
      `GFX_IDX_ACC_MODE:  reg_rd = acc_mode_q;
      `GFX_IDX_WIN_CTRL:  reg_rd = {4'h0, win_ctrl_q};
      `GFX_IDX_CMP_EN:    reg_rd = {4'h0, cmp_en_q};
      `GFX_IDX_WR_MASK:   reg_rd = wr_mask_q;
      default:            reg_rd = 8'h00;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      io_rdata_q <= 8'h00;
    end else if (io_rd) begin
      if (io_addr == `GFX_PORT_INDEX) begin
        io_rdata_q <= {4'h0, index_q};
      end else if (data_rd) begin
        io_rdata_q <= reg_rd;
      end else begin
        io_rdata_q <= 8'h00;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      graphics_mode_q <= 1'b0;
    end else begin
      graphics_mode_q <= win_ctrl_q[`GFX_WC_GRAPHICS];
    end
  end

  // Host window decode and offset
  always_comb begin
    case (win_ctrl_q[3:2])
      2'b00: begin
        win_hit = host_addr[19:17] == `GFX_WIN_A000_128;
        win_off = host_addr[16:0];
      end
      2'b01: begin
        win_hit = host_addr[19:16] == `GFX_WIN_A000_64;
        win_off = {1'b0, host_addr[15:0]};
      end
      2'b10: begin
        win_hit = host_addr[19:15] == `GFX_WIN_B000_32;
        win_off = {2'b00, host_addr[14:0]};
      end
      default: begin
        win_hit = host_addr[19:15] == `GFX_WIN_B800_32;
        win_off = {2'b00, host_addr[14:0]};
      end
    endcase
  end

  // Map addressing, write steering and read plane choice
  always_comb begin
    if (seq_chain4) begin
      map_addr  = {1'b0, win_off[16:2]};
      wr_planes = 4'h1 << win_off[1:0];
      rd_plane  = win_off[1:0];
    end else if (odd_even) begin
      map_addr  = {win_off[15:1], win_off[16]};
      wr_planes = win_off[0] ? 4'hA : 4'h5;
      rd_plane  = {read_plane_q[1], win_off[0]};
    end else begin
      map_addr  = win_off[15:0];
      wr_planes = 4'hF;
      rd_plane  = read_plane_q;
    end
  end

  // Write datapath: rotate, source select, function, mask merge
  assign rot = 8'((({host_wdata, host_wdata}) >> rotate_q[2:0]));

  always_comb begin
    for (int k = 0; k < 4; k++) begin
      case (wmode)
        WMODE_0: wr_src[8*k +: 8] = sr_enable_q[k] ?
                                    {8{setreset_q[k]}} : rot;
        WMODE_2: wr_src[8*k +: 8] = {8{host_wdata[k]}};
        default: wr_src[8*k +: 8] = {8{setreset_q[k]}};
      endcase
    end
  end

  always_comb begin
    case (alu_fn)
      FN_AND:  wr_alu = wr_src & latch_q;
      FN_OR:   wr_alu = wr_src | latch_q;
      FN_XOR:  wr_alu = wr_src ^ latch_q;
      default: wr_alu = wr_src;
    endcase
  end

  assign wr_bits = (wmode == WMODE_3) ? (rot & wr_mask_q) : wr_mask_q;

  always_comb begin
    if (wmode == WMODE_1) begin
      wr_word = latch_q;
    end else begin
      wr_word = (wr_alu & {4{wr_bits}}) |
                (latch_q & ~{4{wr_bits}});
    end
  end

  // Colour compare over enabled maps
  always_comb begin
    for (int b = 0; b < 8; b++) begin
      cmp_byte[b] = 1'b1;
      for (int k = 0; k < 4; k++) begin
        cmp_byte[b] = cmp_byte[b] & ~(cmp_en_q[k] &
                      (map_rdata[8*k + b] ^ cmp_color_q[k]));
      end
    end
  end

  // Host cycle sequencing through the map FIFO
  assign take_rd = (state_q == ST_IDLE) && mem_rd && win_hit &&
                   fifo_in_ready;
  assign take_wr = (state_q == ST_IDLE) && mem_wr && !mem_rd &&
                   win_hit && fifo_in_ready;

  always_comb begin
    fifo_in.we     = take_wr;
    fifo_in.planes = wr_planes & seq_map_mask;
    fifo_in.addr   = map_addr;
    fifo_in.data   = wr_word;
    if (take_rd) begin
      fifo_in.planes = 4'hF;
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      state_q    <= ST_IDLE;
      rd_plane_q <= 2'h0;
      rd_cmp_q   <= 1'b0;
    end else begin
      case (state_q)
        ST_IDLE: if (take_rd) begin
          state_q    <= ST_RD_WAIT;
          rd_plane_q <= rd_plane;
          rd_cmp_q   <= acc_mode_q[`GFX_AM_READ_CMP];
        end
        ST_RD_WAIT: if (map_rvalid) begin
          state_q <= ST_IDLE;
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      latch_q      <= 32'h0000_0000;
      host_rdata_q <= 8'h00;
    end else if (state_q == ST_RD_WAIT && map_rvalid) begin
      latch_q <= map_rdata;
      if (rd_cmp_q) begin
        host_rdata_q <= cmp_byte;
      end else begin
        host_rdata_q <= map_rdata[8*rd_plane_q +: 8];
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      host_ack_q   <= 1'b0;
      host_ready_q <= 1'b0;
    end else begin
      host_ack_q   <= take_wr || (state_q == ST_RD_WAIT && map_rvalid);
      host_ready_q <= fifo_in_ready && (state_q == ST_IDLE) &&
                      !take_rd;
    end
  end

  gfx_fifo #(
    .WIDTH ($bits(map_req_t)),
    .DEPTH (4)
  ) u_fifo (
    .mclk      (mclk),
    .reset     (reset),
    .in_valid  (take_rd || take_wr),
    .in_ready  (fifo_in_ready),
    .in_data   (fifo_in),
    .out_valid (fifo_out_valid),
    .out_ready (map_ready || !map_valid_q),
    .out_data  (fifo_out)
  );

  // Output stage toward the maps
  always_ff @(posedge mclk) begin
    if (reset) begin
      map_valid_q <= 1'b0;
      map_req_q   <= '0;
    end else if (map_ready || !map_valid_q) begin
      map_valid_q <= fifo_out_valid;
      map_req_q   <= fifo_out;
    end
  end

  // Shift register load arrangements
  always_comb begin
    for (int j = 0; j < 4; j++) begin
      for (int s = 0; s < 8; s++) begin
        if (acc_mode_q[`GFX_AM_256]) begin
          load_val[j][7-s] = shift_data[8*(s/2) + j + 4*(1 - s%2)];
        end else if (acc_mode_q[`GFX_AM_SHIFT]) begin
          load_val[j][7-s] = shift_data[8*((j/2)*2 + s/4) +
                                        6 - 2*(s%4) + j%2];
        end else begin
          load_val[j][7-s] = shift_data[8*j + 7 - s];
        end
      end
    end
  end

  for (genvar g = 0; g < 4; g++) begin : g_shift
    gfx_shifter u_sh (
      .mclk     (mclk),
      .reset    (reset),
      .load     (shift_load),
      .shift    (dot_en),
      .load_val (load_val[g]),
      .msb      (sr_msb[g])
    );
  end

  // Pixel output: palette index low bits and the top colour bits
  always_ff @(posedge mclk) begin
    if (reset) begin
      prev_nib_q       <= 4'h0;
      pixel_out_low_q  <= 6'h00;
      pixel_out_bit6_q <= 1'b0;
      pixel_out_bit7_q <= 1'b0;
    end else if (dot_en) begin
      prev_nib_q <= sr_msb;
      if (acc_mode_q[`GFX_AM_256]) begin
        pixel_out_low_q  <= {prev_nib_q[1:0], sr_msb};
        pixel_out_bit6_q <= prev_nib_q[2];
        pixel_out_bit7_q <= prev_nib_q[3];
      end else begin
        pixel_out_low_q  <= {2'b00, sr_msb};
        pixel_out_bit6_q <= color_select[2];
        pixel_out_bit7_q <= color_select[3];
      end
    end
  end

  // Checks
  property p_idx;
    @(posedge mclk) disable iff (reset)
    io_wr && io_addr == `GFX_PORT_INDEX |=> index_q == $past(io_wdata[3:0]);
  endproperty
  a_idx: assert property (p_idx) else $error("index not taken");

  property p_mask_rd;
    @(posedge mclk) disable iff (reset)
    data_wr && index_q == `GFX_IDX_WR_MASK ##1 (!data_wr) [*3] ##1
    data_rd && index_q == `GFX_IDX_WR_MASK |=>
    io_rdata_q == $past(io_wdata, 5);
  endproperty
  a_mask_rd: assert property (p_mask_rd) else $error("mask readback");

  property p_resv;
    @(posedge mclk) disable iff (reset)
    data_rd && index_q == `GFX_IDX_READ_PLN |=> io_rdata_q[7:2] == 6'h00;
  endproperty
  a_resv: assert property (p_resv) else $error("reserved bits set");

  property p_cmp_rd;
    @(posedge mclk) disable iff (reset)
    state_q == ST_RD_WAIT && map_rvalid && rd_cmp_q |=>
    host_rdata_q == $past(cmp_byte) && latch_q == $past(map_rdata);
  endproperty
  a_cmp_rd: assert property (p_cmp_rd) else $error("compare read");

  property p_map_rd;
    @(posedge mclk) disable iff (reset)
    take_rd && !acc_mode_q[`GFX_AM_READ_CMP] && !seq_chain4 && !odd_even
    ##[1:8] (map_rvalid && state_q == ST_RD_WAIT) |=>
    host_rdata_q == $past(map_rdata[8*read_plane_q +: 8]);
  endproperty
  a_map_rd: assert property (p_map_rd) else $error("plane read");

  property p_mode1;
    @(posedge mclk) disable iff (reset)
    take_wr && wmode == WMODE_1 |-> fifo_in.we && fifo_in.data == latch_q;
  endproperty
  a_mode1: assert property (p_mode1) else $error("mode 1 data");

  property p_keep;
    @(posedge mclk) disable iff (reset)
    wmode != WMODE_1 |-> ((wr_word ^ latch_q) & ~{4{wr_bits}}) == '0;
  endproperty
  a_keep: assert property (p_keep) else $error("masked bit changed");

  property p_oe;
    @(posedge mclk) disable iff (reset)
    take_wr && odd_even && !seq_chain4 |->
    (fifo_in.planes & (win_off[0] ? 4'h5 : 4'hA)) == 4'h0;
  endproperty
  a_oe: assert property (p_oe) else $error("odd/even steering");

  property p_win;
    @(posedge mclk) disable iff (reset)
    win_ctrl_q[3:2] == 2'b11 && host_addr[19:15] == 5'h16 |-> !win_hit;
  endproperty
  a_win: assert property (p_win) else $error("window decode");

  property p_top;
    @(posedge mclk) disable iff (reset)
    dot_en && !acc_mode_q[`GFX_AM_256] |=>
    pixel_out_bit7_q == $past(color_select[3]) && pixel_out_low_q[5:4] == 2'h0;
  endproperty
  a_top: assert property (p_top) else $error("top colour bits");

  c_wr: cover property (@(posedge mclk) disable iff (reset) take_wr);
  c_rd: cover property (@(posedge mclk) disable iff (reset)
    take_rd ##[1:8] host_ack_q);
  c_full: cover property (@(posedge mclk) disable iff (reset)
    !fifo_in_ready);

endmodule
`default_nettype wire

// ### gfx_defines.svh
/*
  Register indices, field positions, reset values and I/O port numbers of
  the graphics datapath. Assumes inclusion by bare name, definitions only.
*/
`ifndef GFX_DEFINES_SVH
`define GFX_DEFINES_SVH

// I/O ports of the index/data pair
`define GFX_PORT_INDEX    16'h03CE
`define GFX_PORT_DATA     16'h03CF

// Register indices behind the data port
`define GFX_IDX_SETRESET  4'h0
`define GFX_IDX_SR_ENABLE 4'h1
`define GFX_IDX_CMP_COLOR 4'h2
`define GFX_IDX_ROTATE    4'h3
`define GFX_IDX_READ_PLN  4'h4
`define GFX_IDX_ACC_MODE  4'h5
`define GFX_IDX_WIN_CTRL  4'h6
`define GFX_IDX_CMP_EN    4'h7
`define GFX_IDX_WR_MASK   4'h8

// Field positions in the access mode register
`define GFX_AM_256        6
`define GFX_AM_SHIFT      5
`define GFX_AM_ODDEVEN    4
`define GFX_AM_READ_CMP   3

// Field positions in the window control register
`define GFX_WC_ODDEVEN    1
`define GFX_WC_GRAPHICS   0

// Reset values
`define GFX_RST_BYTE      8'h00
`define GFX_RST_MASK      8'hFF

// Host window bases, upper physical address bits
`define GFX_WIN_A000_128  3'h5
`define GFX_WIN_A000_64   4'hA
`define GFX_WIN_B000_32   5'h16
`define GFX_WIN_B800_32   5'h17

`endif

// ### gfx_fifo.sv
/*
  Small synchronous FIFO with valid/ready on both sides.
  Assumes one clock and a synchronous active-high reset.
*/
`timescale 1ns/1ps
`default_nettype none

module gfx_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  // Clock and reset
  input  wire logic             mclk,
  input  wire logic             reset,
  // Filling side
  input  wire logic             in_valid,
  output var  logic             in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // Draining side
  output var  logic             out_valid,
  input  wire logic             out_ready,
  output var  logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0]    wr_q;
  logic [AW-1:0]    rd_q;
  logic [AW:0]      cnt_q;
  logic             push;
  logic             pop;

  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  assign in_ready  = (cnt_q != (AW+1)'(DEPTH));
  assign out_valid = (cnt_q != '0);
  assign out_data  = mem_q[rd_q];

  always_ff @(posedge mclk) begin
    if (push) begin
      mem_q[wr_q] <= in_data;
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end else begin
      if (push) begin
        wr_q <= (wr_q == AW'(DEPTH-1)) ? '0 : wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= (rd_q == AW'(DEPTH-1)) ? '0 : rd_q + 1'b1;
      end
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

endmodule
`default_nettype wire

// ### gfx_pkg.sv
/*
  Types shared by the graphics datapath files.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package gfx_pkg;

  typedef enum logic [1:0] {
    WMODE_0,
    WMODE_1,
    WMODE_2,
    WMODE_3
  } wmode_t;

  typedef enum logic [1:0] {
    FN_PASS,
    FN_AND,
    FN_OR,
    FN_XOR
  } alu_fn_t;

  typedef enum {
    ST_IDLE,
    ST_RD_WAIT
  } host_state_t;

  // One request toward the four display maps
  typedef struct packed {
    logic        we;
    logic [3:0]  planes;
    logic [15:0] addr;
    logic [31:0] data;
  } map_req_t;

endpackage

// ### gfx_shifter.sv
/*
  One 8-bit video shift register, loaded in parallel, shifted MSB first.
  Assumes load and shift enables from the same clock domain.
*/
`timescale 1ns/1ps
`default_nettype none

module gfx_shifter (
  // Clock and reset
  input  wire logic       mclk,
  input  wire logic       reset,
  // Control and data
  input  wire logic       load,
  input  wire logic       shift,
  input  wire logic [7:0] load_val,
  output var  logic       msb
);
  logic [7:0] sr_q;

  always_ff @(posedge mclk) begin
    if (reset) begin
      sr_q <= 8'h00;
    end else if (load) begin
      sr_q <= load_val;
    end else if (shift) begin
      sr_q <= {sr_q[6:0], 1'b0};
    end
  end

  assign msb = sr_q[7];

endmodule
`default_nettype wire

// ### map_model.sv
/* Display map memory model on the far side of the map port.
   Assumes the datapath's map port on the same clock. */
`timescale 1ns/1ps
`default_nettype none
module map_model
  import gfx_pkg::*;
(
  // Clock, reset and stall control
  input  wire logic        mclk,
  input  wire logic        reset,
  input  wire logic        stall,
  // Map port
  input  wire logic        map_valid_q,
  output var  logic        map_ready,
  input  wire map_req_t    map_req_q,
  output var  logic        map_rvalid,
  output var  logic [31:0] map_rdata
);
  logic [31:0] mem [16];
  assign map_ready = !stall;
  always_ff @(posedge mclk) begin
    map_rvalid <= 1'b0;
    // Idle bus toggles so stale data is never mistaken for an answer
    map_rdata <= ~map_rdata;
    if (reset) begin
      map_rdata <= 32'h0000_0000;
    end else if (map_valid_q && map_ready) begin
      if (map_req_q.we) begin
        for (int k = 0; k < 4; k++) begin
          if (map_req_q.planes[k]) begin
            mem[map_req_q.addr[3:0]][8*k +: 8] <= map_req_q.data[8*k +: 8];
          end
        end
      end else begin
        map_rvalid <= 1'b1;
        map_rdata <= mem[map_req_q.addr[3:0]];
      end
    end
  end
endmodule
`default_nettype wire

// ### vga_graphics_memory_datapath_test.sv
/* Self-checking bench for the graphics datapath.
   Assumes map_model stands behind the map port. */
`timescale 1ns/1ps
`default_nettype none
module vga_graphics_memory_datapath_test;
  import gfx_pkg::*;
  logic mclk = 0, reset = 1, stall = 0, ok, io_wr = 0, io_rd = 0;
  logic mem_rd = 0, mem_wr = 0, shift_load = 0, dot_en = 0, seq_chain4 = 0;
  logic [15:0] io_addr = 0;
  logic [7:0] io_wdata = 0, host_wdata = 0, io_rdata_q, host_rdata_q, v;
  logic [19:0] host_addr = 0;
  logic [3:0] seq_map_mask = 4'hF, color_select = 4'hC;
  logic [31:0] shift_data = 0, map_rdata;
  logic host_ready_q, host_ack_q, map_valid_q, map_ready, map_rvalid;
  logic pixel_out_bit6_q, pixel_out_bit7_q, graphics_mode_q;
  logic [5:0] pixel_out_low_q;
  map_req_t map_req_q;
  int err_count = 0, total_checks = 0, n;
  // Index, written value, value read back
  logic [19:0] rows [10] = '{20'h4FF03, 20'h40000, 20'h5FF7B, 20'h50000,
    20'h6FF0F, 20'h60101, 20'h7FF0F, 20'h85A5A, 20'h8FFFF, 20'h9FF00};
  always #12.5 mclk = ~mclk;
  gfx_datapath i_dut (.mclk, .reset, .io_addr, .io_wr, .io_rd, .io_wdata,
    .io_rdata_q, .mem_rd, .mem_wr, .host_addr, .host_wdata, .host_ready_q,
    .host_ack_q, .host_rdata_q, .seq_map_mask, .seq_chain4, .color_select,
    .map_valid_q, .map_ready, .map_req_q, .map_rvalid, .map_rdata,
    .shift_load, .dot_en, .shift_data, .pixel_out_low_q, .pixel_out_bit6_q,
    .pixel_out_bit7_q, .graphics_mode_q);
  map_model i_map (.mclk, .reset, .stall, .map_valid_q, .map_ready,
    .map_req_q, .map_rvalid, .map_rdata);
  task wrap_up;
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    total_checks++;
    if (g !== e) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task io(input logic w, input logic [15:0] a, input logic [7:0] d);
    io_addr = a;
    io_wdata = d;
    io_wr = w;
    io_rd = !w;
    @(posedge mclk) #1;
    io_wr = 0;
    io_rd = 0;
    @(posedge mclk) #1;
  endtask
  task wr(input logic [3:0] i, input logic [7:0] d);
    io(1, 16'h03CE, {4'h0, i});
    io(1, 16'h03CF, d);
  endtask
  task rd(input logic [3:0] i);
    io(1, 16'h03CE, {4'h0, i});
    io(0, 16'h03CF, 8'h00);
    v = io_rdata_q;
  endtask
  // Holds the request until acknowledged or the limit runs out
  task mem(input logic r, input logic [19:0] a, input logic [7:0] d,
           input int lim);
    host_addr = a;
    host_wdata = d;
    mem_rd = r;
    mem_wr = !r;
    ok = 0;
    for (int i = 0; i < lim && !ok; i++) begin
      @(posedge mclk) #1;
      ok = (host_ack_q === 1'b1);
    end
    mem_rd = 0;
    mem_wr = 0;
    v = host_rdata_q;
    @(posedge mclk) #1;
  endtask
  task rdm(input logic [1:0] p, input logic [19:0] a, input logic [7:0] e);
    wr(4, {6'h00, p});
    mem(1, a, 8'h00, 20);
    chk("map read", e, v);
  endtask
  // Loads the shift registers, then runs k dot clocks
  task px(input logic [31:0] d, input int k);
    shift_data = d;
    shift_load = 1;
    @(posedge mclk) #1 shift_load = 0;
    dot_en = 1;
    repeat (k) @(posedge mclk) #1;
    dot_en = 0;
    @(posedge mclk) #1;
  endtask
  initial begin
    repeat (12) @(posedge mclk);
    #1 reset = 0;
    for (int i = 4; i < 10; i++) begin
      rd(4'(i));
      chk("reset value", (i == 8) ? 8'hFF : 8'h00, v);
    end
    foreach (rows[i]) begin
      wr(rows[i][19:16], rows[i][15:8]);
      rd(rows[i][19:16]);
      chk("register", rows[i][7:0], v);
    end
    chk("graphics bit", 8'h01, {7'h0, graphics_mode_q});
    wr(3, 8'h03);
    wr(0, 8'h04);
    wr(1, 8'h04);
    mem(0, 20'hA0000, 8'h01, 20);
    rdm(0, 20'hA0000, 8'h20);
    rdm(2, 20'hA0000, 8'hFF);
    rdm(3, 20'hA0000, 8'h20);
    wr(1, 8'h00);
    wr(3, 8'h18);
    wr(8, 8'h0F);
    mem(0, 20'hA0000, 8'h0F, 20);
    rdm(0, 20'hA0000, 8'h2F);
    rdm(2, 20'hA0000, 8'hF0);
    wr(3, 8'h00);
    wr(8, 8'hFF);
    wr(5, 8'h02);
    mem(0, 20'hA0000, 8'h05, 20);
    rdm(0, 20'hA0000, 8'hFF);
    rdm(1, 20'hA0000, 8'h00);
    wr(5, 8'h08);
    wr(2, 8'h05);
    rdm(1, 20'hA0000, 8'hFF);
    wr(7, 8'h01);
    wr(2, 8'h00);
    rdm(0, 20'hA0000, 8'h00);
    wr(5, 8'h01);
    mem(0, 20'hA0001, 8'h00, 20);
    wr(5, 8'h00);
    rdm(0, 20'hA0001, 8'hFF);
    rdm(1, 20'hA0001, 8'h00);
    wr(5, 8'h03);
    mem(0, 20'hA0001, 8'h0F, 20);
    rdm(0, 20'hA0001, 8'hF0);
    wr(5, 8'h00);
    wr(6, 8'h0D);
    mem(0, 20'hB0000, 8'h00, 8);
    chk("outside window", 8'h00, {7'h0, ok});
    mem(0, 20'hB8002, 8'h00, 20);
    chk("inside window", 8'h01, {7'h0, ok});
    wr(6, 8'h01);
    wr(5, 8'h10);
    mem(0, 20'hA0005, 8'h3C, 20);
    rdm(0, 20'hA0005, 8'h3C);
    rdm(2, 20'hA0005, 8'h3C);
    wr(5, 8'h00);
    seq_chain4 = 1;
    mem(0, 20'hA0006, 8'h77, 20);
    rdm(0, 20'hA0006, 8'h77);
    seq_chain4 = 0;
    stall = 1;
    n = 0;
    for (int i = 0; i < 8 && (i == n); i++) begin
      mem(0, 20'hA0003, 8'(i), 6);
      n += int'(ok);
    end
    chk("fifo fill", 8'h05, 8'(n));
    chk("ready when full", 8'h00, {7'h0, host_ready_q});
    stall = 0;
    repeat (10) @(posedge mclk) #1;
    chk("ready when idle", 8'h01, {7'h0, host_ready_q});
    rdm(0, 20'hA0003, 8'(n - 1));
    px(32'hFF00_FF00, 3);
    chk("pixel low", 8'h0A, {2'h0, pixel_out_low_q});
    chk("pixel top", 8'h03, {6'h0, pixel_out_bit7_q, pixel_out_bit6_q});
    wr(5, 8'h40);
    px(32'h0000_00A5, 2);
    chk("pixel 256 low", 8'h25, {2'h0, pixel_out_low_q});
    chk("pixel 256 top", 8'h02, {6'h0, pixel_out_bit7_q, pixel_out_bit6_q});
    wrap_up();
  end
  initial begin
    #300000;
    err_count++;
    wrap_up();
  end
endmodule
`default_nettype wire
